// [verilog/pdt_pkg.sv]
// Function
// RL1: Software reads low nibble first, high soon after
// RL2: Low nibble read never freezes high nibble
// RL3: Stop timer before reading fast-clocked counter
// RL4: Fast source divides by one, four, thirty-two
// RL5: Sixteen-bit reads go lowest nibble to highest
// RL6: Run or stop waits for input falling edge
// RL7: Stopping performs one last decrement first
// RL8: Run bit reads one until really stopped
// RL9: Event mode also waits for input edge
// RL10: Output gate acts unsynchronised, may glitch
// RL11: Software waits oscillator settling before start
// RL12: Fast oscillator off after reset
// RL13: Decrement on falling edge, underflow interrupt there
// RL14: Reload value settles on next rising edge
// RL15: Software keeps reload stable until settled
// RL16: Cause flag sets regardless of mask
// RL17: Write one clears flag; uncleared flag re-requests
// RL18: Sixteen-bit mode cascades, single reload and interrupt
package pdt_pkg;

    // ---------------------------------------------------------------
    // Bus geometry
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W  = 8;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL       = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_CLKSEL     = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_RELOAD     = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_CNT0_LOW   = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_CNT0_HIGH  = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_CNT1_LOW   = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_CNT1_HIGH  = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 6'h20;

    // ---------------------------------------------------------------
    // Control register fields
    // ---------------------------------------------------------------
    localparam int unsigned CTRL_RUN0   = 0;
    localparam int unsigned CTRL_RUN1   = 1;
    localparam int unsigned CTRL_MODE16 = 2;
    localparam int unsigned CTRL_GATE   = 3;
    localparam int unsigned CTRL_OSC_ON = 4;

    // ---------------------------------------------------------------
    // Clock select fields, one nibble per channel
    // ---------------------------------------------------------------
    localparam int unsigned SEL_SRC   = 0;
    localparam int unsigned SEL_DIV   = 1;
    localparam int unsigned SEL_EVENT = 3;
    localparam int unsigned SEL_STEP  = 4;
    localparam logic [1:0]  DIV_BY1   = 2'h0;
    localparam logic [1:0]  DIV_BY4   = 2'h1;
    localparam logic [1:0]  DIV_BY32  = 2'h2;
    localparam int unsigned PRE_W     = 5;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [4:0]       RST_CTRL   = 5'h00;
    localparam logic [7:0]       RST_CLKSEL = 8'h00;
    localparam logic [15:0]      RST_RELOAD = 16'h0000;
    localparam logic [CNT_W-1:0] RST_COUNT  = 8'h00;
    localparam logic [1:0]       RST_IRQ    = 2'h0;

endpackage : pdt_pkg

// [verilog/pdt_channel.sv]
`timescale 1ns/1ps
`default_nettype none

// One down-counting channel with reload; sequencing lives in the parent
module pdt_channel #(
    parameter int unsigned WIDTH = pdt_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             srst_i,
    // Count control
    input  wire logic             dec_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] reload_i,
    // Status
    output logic      [WIDTH-1:0] count_o,
    output logic                  zero_o
);
    import pdt_pkg::*;

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    // Load beats decrement; both never coincide since load waits a rising edge
    always_comb begin
        next_count = count;
        if (load_i) begin
            next_count = reload_i;                        // see RL14
        end else if (dec_i) begin
            next_count = count - {{(WIDTH-1){1'b0}}, 1'b1}; // see RL13
        end
    end

    // Register stage
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            count <= WIDTH'(RST_COUNT);
        end else begin
            count <= next_count;
        end
    end

    assign count_o = count;
    assign zero_o  = (count == '0);

endmodule : pdt_channel

`default_nettype wire

// [verilog/pdt_timer.sv]
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pdt_timer (
    // Clock and reset
    input  wire logic                        clock_i,
    input  wire logic                        srst_i,
    // Avalon-MM slave
    input  wire logic [pdt_pkg::ADDR_W-1:0]  avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic [pdt_pkg::DATA_W-1:0]  avs_writedata_i,
    input  wire logic [3:0]                  avs_byteenable_i,
    output logic      [pdt_pkg::DATA_W-1:0]  avs_readdata_o,
    output logic                             avs_waitrequest_o,
    // Oscillator and event pins
    input  wire logic                        low_speed_osc_i,
    input  wire logic                        high_speed_osc_i,
    input  wire logic                        event_in_i,
    output logic                             high_speed_osc_en_o,
    // Timer output and interrupt
    output logic                             timer_output_signal_o,
    output logic                             irq_o
);
    import pdt_pkg::*;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] sync_a;   // Stage one, read only by stage two
    logic [2:0] sync_b;
    logic [2:0] next_sync_a;
    logic [2:0] next_sync_b;
    logic       low_lvl;
    logic       high_lvl;
    logic       event_lvl;

    // Two flops per pin before anything looks at it
    always_comb begin
        next_sync_a = {event_in_i, high_speed_osc_i, low_speed_osc_i};
        next_sync_b = sync_a;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    assign low_lvl   = sync_b[0];
    assign high_lvl  = sync_b[1];
    assign event_lvl = sync_b[2];

    // ---------------------------------------------------------------
    // Software registers
    // ---------------------------------------------------------------
    logic [4:0]  ctrl;
    logic [7:0]  clksel;
    logic [15:0] reload;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [4:0]  next_ctrl;
    logic [7:0]  next_clksel;
    logic [15:0] next_reload;
    logic [1:0]  next_irq_status;
    logic [1:0]  next_irq_mask;

    // ---------------------------------------------------------------
    // High-speed prescaler
    // ---------------------------------------------------------------
    logic             high_prev;
    logic [PRE_W-1:0] pre_cnt;
    logic             next_high_prev;
    logic [PRE_W-1:0] next_pre_cnt;

    // Counts only while the oscillator is switched on
    always_comb begin
        next_high_prev = high_lvl & ctrl[CTRL_OSC_ON];
        next_pre_cnt   = pre_cnt;
        if (next_high_prev && !high_prev) begin
            next_pre_cnt = pre_cnt + PRE_W'(1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            high_prev <= 1'b0;
            pre_cnt   <= '0;
        end else begin
            high_prev <= next_high_prev;
            pre_cnt   <= next_pre_cnt;
        end
    end

    // ---------------------------------------------------------------
    // Per-channel input clock and edge detection
    // ---------------------------------------------------------------
    logic [1:0] in_clk;
    logic [1:0] in_prev;
    logic [1:0] next_in_prev;
    logic [1:0] fall;
    logic [1:0] rise;

    // Pick event pin, low-speed oscillator or a divided fast clock
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            logic [3:0] sel;
            sel        = clksel[ch*SEL_STEP +: SEL_STEP];
            in_clk[ch] = low_lvl;
            if (sel[SEL_EVENT]) begin
                in_clk[ch] = event_lvl;                   // see RL9
            end else if (sel[SEL_SRC]) begin
                case (sel[SEL_DIV +: 2])
                    DIV_BY1:  in_clk[ch] = high_prev;     // see RL4
                    DIV_BY4:  in_clk[ch] = pre_cnt[1];    // see RL4
                    DIV_BY32: in_clk[ch] = pre_cnt[4];    // see RL4
                    default:  in_clk[ch] = 1'b0;
                endcase
            end
        end
        next_in_prev = in_clk;
        fall         = in_prev & ~in_clk;
        rise         = ~in_prev & in_clk;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            in_prev <= 2'h0;
        end else begin
            in_prev <= next_in_prev;
        end
    end

    // ---------------------------------------------------------------
    // Run synchronisation, cascade, reload and events
    // ---------------------------------------------------------------
    logic [1:0]       run_act;
    logic [1:0]       load_pend;
    logic             timer_output_signal;
    logic [1:0]       next_run_act;
    logic [1:0]       next_load_pend;
    logic             next_timer_output_signal;
    logic [1:0]       dec;
    logic [1:0]       uflow;
    logic [1:0]       load;
    logic [1:0]       event_hit;
    logic [1:0]       zero;
    logic [CNT_W-1:0] count0;
    logic [CNT_W-1:0] count1;
    logic             mode16;

    assign mode16 = ctrl[CTRL_MODE16];

    // Run takes effect only on a falling input edge; the old state decides
    // that edge's decrement, so a stop still counts once
    always_comb begin
        next_run_act = run_act;
        for (int ch = 0; ch < 2; ch++) begin
            if (fall[ch]) begin
                next_run_act[ch] = ctrl[CTRL_RUN0 + ch];  // see RL6
            end
        end
        dec[0]   = fall[0] & run_act[0];                  // see RL7
        uflow[0] = dec[0] & zero[0];
        if (mode16) begin
            dec[1] = uflow[0];                            // see RL18
        end else begin
            dec[1] = fall[1] & run_act[1];                // see RL7
        end
        uflow[1] = dec[1] & zero[1];
        // Interrupt raised on the same edge as the underflow
        if (mode16) begin
            event_hit = {1'b0, uflow[1]};                 // see RL18
        end else begin
            event_hit = uflow;                            // see RL13
        end
        // Reload waits for the following rising edge of the input clock
        next_load_pend = load_pend;
        load           = 2'h0;
        for (int ch = 0; ch < 2; ch++) begin
            logic r;
            r        = mode16 ? rise[0] : rise[ch];
            load[ch] = load_pend[ch] & r;                 // see RL14
            if (load[ch]) begin
                next_load_pend[ch] = 1'b0;
            end
        end
        if (mode16) begin
            if (uflow[1]) begin
                next_load_pend = 2'h3;                    // see RL18
            end
        end else begin
            next_load_pend = next_load_pend | uflow;      // see RL14
        end
        next_timer_output_signal = timer_output_signal ^ event_hit[0];
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            run_act   <= 2'h0;
            load_pend <= 2'h0;
            timer_output_signal      <= 1'b0;
        end else begin
            run_act   <= next_run_act;
            load_pend <= next_load_pend;
            timer_output_signal      <= next_timer_output_signal;
        end
    end

    // ---------------------------------------------------------------
    // Counter channels
    // ---------------------------------------------------------------
    pdt_channel #(
        .WIDTH (CNT_W)
    ) u_chan0 (
        .clock_i  (clock_i),
        .srst_i   (srst_i),
        .dec_i    (dec[0]),
        .load_i   (load[0]),
        .reload_i (reload[7:0]),
        .count_o  (count0),
        .zero_o   (zero[0])
    );

    pdt_channel #(
        .WIDTH (CNT_W)
    ) u_chan1 (
        .clock_i  (clock_i),
        .srst_i   (srst_i),
        .dec_i    (dec[1]),
        .load_i   (load[1]),
        .reload_i (reload[15:8]),
        .count_o  (count1),
        .zero_o   (zero[1])
    );

    // ---------------------------------------------------------------
    // Avalon-MM slave
    // ---------------------------------------------------------------
    logic              ack;
    logic [DATA_W-1:0] rdata;
    logic              next_ack;
    logic [DATA_W-1:0] next_rdata;
    logic              req;
    logic              wr_take;
    logic [DATA_W-1:0] be_mask;

    // One wait state: first cycle latches read data, second completes
    assign req     = avs_read_i | avs_write_i;
    assign wr_take = avs_write_i & ack;
    assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

    // Read mux; counter nibbles are live, nothing is latched on a low read
    always_comb begin
        next_ack   = req & ~ack;
        next_rdata = rdata;
        if (avs_read_i && !ack) begin
            next_rdata = '0;
            case (avs_address_i)
                OFS_CTRL:       next_rdata = {27'h0, ctrl[4:2],
                                              ctrl[1:0] | run_act};  // see RL8
                OFS_CLKSEL:     next_rdata = {24'h0, clksel};
                OFS_RELOAD:     next_rdata = {16'h0, reload};
                OFS_CNT0_LOW:   next_rdata = {28'h0, count0[3:0]};   // see RL2
                OFS_CNT0_HIGH:  next_rdata = {28'h0, count0[7:4]};   // see RL2
                OFS_CNT1_LOW:   next_rdata = {28'h0, count1[3:0]};
                OFS_CNT1_HIGH:  next_rdata = {28'h0, count1[7:4]};
                OFS_IRQ_STATUS: next_rdata = {30'h0, irq_status};
                OFS_IRQ_MASK:   next_rdata = {30'h0, irq_mask};
                default:        next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ack   <= 1'b0;
            rdata <= '0;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign avs_waitrequest_o = req & ~ack;
    assign avs_readdata_o    = rdata;

    // ---------------------------------------------------------------
    // Register writes and interrupt flags
    // ---------------------------------------------------------------
    always_comb begin
        logic [DATA_W-1:0] wd;
        wd              = avs_writedata_i & be_mask;
        next_ctrl       = ctrl;
        next_clksel     = clksel;
        next_reload     = reload;
        next_irq_mask   = irq_mask;
        next_irq_status = irq_status;
        if (wr_take) begin
            case (avs_address_i)
                OFS_CTRL: begin
                    next_ctrl = (ctrl & ~be_mask[4:0]) | wd[4:0];
                end
                OFS_CLKSEL: begin
                    next_clksel = (clksel & ~be_mask[7:0]) | wd[7:0];
                end
                OFS_RELOAD: begin
                    next_reload = (reload & ~be_mask[15:0]) | wd[15:0];
                end
                OFS_IRQ_MASK: begin
                    next_irq_mask = (irq_mask & ~be_mask[1:0]) | wd[1:0];
                end
                OFS_IRQ_STATUS: begin
                    next_irq_status = irq_status & ~wd[1:0];  // see RL17
                end
                default: begin
                    next_ctrl = ctrl;
                end
            endcase
        end
        // Set wins over a same-cycle clear; mask plays no part here
        next_irq_status = next_irq_status | event_hit;        // see RL16
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ctrl       <= RST_CTRL;                           // see RL12
            clksel     <= RST_CLKSEL;
            reload     <= RST_RELOAD;
            irq_status <= RST_IRQ;
            irq_mask   <= RST_IRQ;
        end else begin
            ctrl       <= next_ctrl;
            clksel     <= next_clksel;
            reload     <= next_reload;
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Level stays high while a flag is uncleared, so it re-requests
    assign irq_o = |(irq_status & irq_mask);                  // see RL17

    // Plain gate: switching it mid-cycle may leave a short pulse
    assign timer_output_signal_o = timer_output_signal & ctrl[CTRL_GATE];    // see RL10

    // Oscillator stays off until software enables it
    assign high_speed_osc_en_o = ctrl[CTRL_OSC_ON];           // see RL12

endmodule : pdt_timer

`default_nettype wire

// [sim/pdt_timer_sva.sv]
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// Port checker for the timer
// ---------------------------------------------------------------
module pdt_timer_sva
    import pdt_pkg::*;
(
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              srst_i,
    // Register bus
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    input  wire logic [DATA_W-1:0] avs_readdata_o,
    input  wire logic              avs_waitrequest_o,
    // Pins
    input  wire logic              low_speed_osc_i,
    input  wire logic              high_speed_osc_i,
    input  wire logic              event_in_i,
    input  wire logic              high_speed_osc_en_o,
    input  wire logic              timer_output_signal_o,
    input  wire logic              irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    // Transfer qualifiers shared by the properties
    logic req;
    logic wr_done;
    logic rd_done;
    assign req     = avs_read_i || avs_write_i;
    assign wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    assign rd_done = avs_read_i && !avs_waitrequest_o;

    chk_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
        else $error("new request not held off for one cycle");
    chk_wait_once: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait state longer than one cycle");
    chk_idle_nowait: assert property (!req |-> !avs_waitrequest_o)
        else $error("waitrequest high while idle");
    chk_hole_zero: assert property (rd_done && avs_address_i > OFS_IRQ_MASK
        |-> avs_readdata_o == '0)
        else $error("unmapped read returned nonzero");
    chk_reset_quiet: assert property ($past(srst_i)
        |-> !irq_o && !high_speed_osc_en_o && !timer_output_signal_o)
        else $error("outputs active after reset");
    chk_osc_follow: assert property (wr_done && avs_address_i == OFS_CTRL
        |=> high_speed_osc_en_o == $past(avs_writedata_i[CTRL_OSC_ON]))
        else $error("oscillator enable does not follow control write");
    chk_gate_off: assert property (wr_done && avs_address_i == OFS_CTRL
        && !avs_writedata_i[CTRL_GATE] |=> !timer_output_signal_o)
        else $error("timer output not gated off");
    chk_mask_off: assert property (wr_done && avs_address_i == OFS_IRQ_MASK
        && avs_writedata_i[1:0] == 2'h0 |=> !irq_o)
        else $error("interrupt high with all sources masked");
    // Status read while interrupt was high must show a set flag
    chk_status_seen: assert property (rd_done && avs_address_i == OFS_IRQ_STATUS
        && $past(irq_o) |-> avs_readdata_o[1:0] != 2'h0)
        else $error("interrupt high but status reads clear");
endmodule : pdt_timer_sva

bind pdt_timer pdt_timer_sva u_sva (
    .clock_i(clock_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .low_speed_osc_i(low_speed_osc_i), .high_speed_osc_i(high_speed_osc_i),
    .event_in_i(event_in_i), .high_speed_osc_en_o(high_speed_osc_en_o),
    .timer_output_signal_o(timer_output_signal_o), .irq_o(irq_o)
);

`default_nettype wire

// [sim/tb_pdt_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_pdt_timer;
    import pdt_pkg::*;

    // ---------------------------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------------------------
    logic              clock_i = 1'b0;
    logic              srst_i = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic              rd_en = 1'b0;
    logic              wr_en = 1'b0;
    logic [DATA_W-1:0] wdata = '0;
    logic              lso = 1'b0;
    logic              evt = 1'b0;
    logic              hso = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic              waitreq;
    logic              osc_en;
    logic              timer_output_signal;
    logic              irq;
    int                miscompares = 0;
    int                total_checks = 0;
    int                cycles = 0;

    typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [DATA_W-1:0] e;} pdt_row_t;
    pdt_row_t rows[6] = '{
        '{OFS_RELOAD, 32'hffff_0302, 32'h0000_0302},
        '{OFS_CLKSEL, 32'h0000_00a5, 32'h0000_00a5},
        '{OFS_CLKSEL, 32'h0000_0000, 32'h0000_0000},
        '{OFS_IRQ_MASK, 32'h0000_0003, 32'h0000_0003},
        '{OFS_IRQ_MASK, 32'h0000_0000, 32'h0000_0000},
        '{6'h3c, 32'hffff_ffff, 32'h0000_0000}};

    always #5 clock_i = ~clock_i;

    pdt_timer u_dut (
        .clock_i(clock_i), .srst_i(srst_i), .avs_address_i(addr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .low_speed_osc_i(lso), .high_speed_osc_i(hso), .event_in_i(evt),
        .high_speed_osc_en_o(osc_en), .timer_output_signal_o(timer_output_signal), .irq_o(irq)
    );

    // ---------------------------------------------------------------
    // Reporting
    // ---------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    // One-bit compare
    task automatic chk_bit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask : chk_bit

    // Hang guard; the whole run needs about five hundred cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ---------------------------------------------------------------
    // Bus and pin drivers
    // ---------------------------------------------------------------
    // Request held until the edge that samples waitrequest low
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clock_i);
        rd_en <= !w;
        wr_en <= w;
        addr  <= a;
        wdata <= d;
        do @(posedge clock_i); while (waitreq !== 1'b0);
        q = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask : bus

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk_word("readdata", e, q);
    endtask : rd

    // Each level is held nine cycles, past the synchroniser
    task automatic pin(input int p, input logic lvl);
        @(posedge clock_i);
        if (p == 1) begin
            evt <= lvl;
        end else if (p == 2) begin
            hso <= lvl;
        end else begin
            lso <= lvl;
        end
        repeat (8) @(posedge clock_i);
    endtask : pin

    task automatic pulse(input int p);
        pin(p, 1'b1);
        pin(p, 1'b0);
    endtask : pulse

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock_i);
        srst_i <= 1'b0;
        @(negedge clock_i);
        chk_bit("osc_en", 1'b0, osc_en);
        chk_bit("irq", 1'b0, irq);
        rd(OFS_CTRL, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        wr(OFS_CTRL, 32'h10);
        @(negedge clock_i);
        chk_bit("osc_en", 1'b1, osc_en);
        // Channel 0 from the low-speed pin, reload 02, mask off
        wr(OFS_RELOAD, 32'h0302);
        wr(OFS_CTRL, 32'h01);
        rd(OFS_CNT0_LOW, 32'h0);
        rd(OFS_CTRL, 32'h01);
        pulse(1'b0);
        rd(OFS_CNT0_LOW, 32'h0);
        pulse(1'b0);
        rd(OFS_CNT0_LOW, 32'hf);
        rd(OFS_CNT0_HIGH, 32'hf);
        rd(OFS_IRQ_STATUS, 32'h1);
        chk_bit("irq", 1'b0, irq);
        pin(1'b0, 1'b1);
        rd(OFS_CNT0_LOW, 32'h2);
        wr(OFS_IRQ_MASK, 32'h1);
        rd(OFS_IRQ_STATUS, 32'h1);
        chk_bit("irq", 1'b1, irq);
        wr(OFS_IRQ_STATUS, 32'h1);
        @(negedge clock_i);
        chk_bit("irq", 1'b0, irq);
        pin(1'b0, 1'b0);
        rd(OFS_CNT0_LOW, 32'h1);
        // Stop: one last decrement, run bit reads one until then
        wr(OFS_CTRL, 32'h0);
        rd(OFS_CTRL, 32'h01);
        pulse(1'b0);
        rd(OFS_CNT0_LOW, 32'h0);
        rd(OFS_CTRL, 32'h0);
        pulse(1'b0);
        rd(OFS_CNT0_LOW, 32'h0);
        // Output toggled once, so the gate alone decides the pin
        wr(OFS_CTRL, 32'h08);
        @(negedge clock_i);
        chk_bit("timer_output_signal", 1'b1, timer_output_signal);
        wr(OFS_CTRL, 32'h0);
        @(negedge clock_i);
        chk_bit("timer_output_signal", 1'b0, timer_output_signal);
        // Event mode ignores the low-speed pin entirely
        wr(OFS_CLKSEL, 32'h08);
        wr(OFS_CTRL, 32'h01);
        pulse(1'b0);
        pulse(1'b0);
        rd(OFS_CNT0_LOW, 32'h0);
        pulse(1'b1);
        pulse(1'b1);
        rd(OFS_CNT0_LOW, 32'hf);
        wr(OFS_CTRL, 32'h0);
        pulse(1'b1);
        rd(OFS_CNT0_LOW, 32'h1);
        // Cascade: 0x0001 counts to 0x0000 then underflows as one
        wr(OFS_IRQ_STATUS, 32'h3);
        wr(OFS_CLKSEL, 32'h0);
        wr(OFS_CTRL, 32'h05);
        pulse(1'b0);
        pulse(1'b0);
        rd(OFS_CNT0_LOW, 32'h0);
        pulse(1'b0);
        rd(OFS_IRQ_STATUS, 32'h1);
        pulse(0);
        rd(OFS_CNT0_LOW, 32'h1);
        rd(OFS_CNT0_HIGH, 32'h0);
        rd(OFS_CNT1_LOW, 32'h3);
        // Fast clock over four: one decrement per four pulses
        wr(OFS_CTRL, 32'h10);
        wr(OFS_CLKSEL, 32'h03);
        wr(OFS_CTRL, 32'h11);
        repeat (3) pulse(2);
        rd(OFS_CNT0_LOW, 32'h1);
        pulse(2);
        wr(OFS_CTRL, 32'h10);
        rd(OFS_CNT0_LOW, 32'h0);
        tally_and_finish();
    end
endmodule : tb_pdt_timer

`default_nettype wire
